/* jtrc_params.svh */
// Constants for the test-access chain and global reset logic
//
// Operation
// - Two TAPs in chain right after reset
// - Boundary TAP behaves as standard TAP
// - Chip TAP reaches tile, switch, OTP
// - Test reset low keeps JTAG in reset
// - DEVICE_IDENTIFICATION_WORD word: version, part, maker, one
// - USERCODE word: user ID plus revision
// - User ID from security bits 31..22
// - Global reset asserts asynchronously, active low
// - Boot only after PLL regains lock
// - Test port synchronous to TCK, reset async
// - Security bit 0 forces both TAPs to bypass at IR update, blocks debug
// - Security bit 13 blocks JTAG OTP access
`ifndef JTRC_PARAMS_SVH
`define JTRC_PARAMS_SVH
`define JTRC_IR_W 4
`define JTRC_IR_CAPTURE 4'h1
`define JTRC_DEVICE_IDENTIFICATION_WORD_LSB 1'b1
`define JTRC_ID_VERSION 4'h0 // Arbitrary value
`define JTRC_ID_PART 16'h0001 // Arbitrary value
`define JTRC_ID_MAKER 11'h055 // Arbitrary value
`define JTRC_UC_FIXED 22'h000123 // Arbitrary value
`define JTRC_USERID_MSB 31
`define JTRC_USERID_LSB 22
`define JTRC_SEC_JTAG_OFF 0
`define JTRC_SEC_JTAG_OTP_OFF 13
`define JTRC_DBG_W 35
`define JTRC_DBG_WRITE 34
`define JTRC_DBG_TGT_MSB 33
`define JTRC_DBG_TGT_LSB 32
`define JTRC_DBG_DONE 34
`define JTRC_DBG_BLOCKED 33
`define JTRC_NUM_PINS 16
`endif

/* jtrc_pkg.sv */
// Types for the test-access chain and global reset logic
package jtrc_pkg;
    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UP_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UP_IR
    } jtrc_tap_type;

    // Boundary TAP instructions
    typedef enum logic [3:0] {
        BS_EXTEST = 4'h0, BS_SAMPLE = 4'h1, BS_DEVICE_IDENTIFICATION_WORD = 4'h2,
        BS_USERCODE = 4'h3, BS_BYPASS = 4'hf
    } jtrc_bs_ins_type;

    // Chip TAP instructions
    typedef enum logic [3:0] {
        CH_DEBUG = 4'h8, CH_BYPASS = 4'hf
    } jtrc_ch_ins_type;

    // Internal targets reached by the chip TAP
    typedef enum logic [1:0] {
        TGT_TILE = 2'h0, TGT_SWITCH = 2'h1, TGT_OTP = 2'h2
    } jtrc_target_type;

    typedef enum logic [1:0] {B_RST, B_WAIT, B_BOOT} jtrc_boot_type;

    // Debug request carried from the TCK side
    typedef struct packed {
        logic write;
        jtrc_target_type target;
        logic [31:0] data;
    } jtrc_dbg_req_type;
endpackage : jtrc_pkg

/* jtrc_top.sv */
// Two-TAP JTAG chain with debug access and global reset sequencing
`timescale 1ns/1ps
`include "jtrc_params.svh"
module jtrc_top #(
    parameter int NPIN = `JTRC_NUM_PINS,
    parameter logic [3:0] ID_VERSION = `JTRC_ID_VERSION, // Arbitrary value
    parameter logic [15:0] ID_PART = `JTRC_ID_PART, // Arbitrary value
    parameter logic [10:0] ID_MAKER = `JTRC_ID_MAKER, // Arbitrary value
    parameter logic [21:0] UC_FIXED = `JTRC_UC_FIXED // Arbitrary revision
) (
    // System clock domain
    input wire logic clk,
    input wire logic srst,
    input wire logic rst_n,
    input wire logic pll_lock,
    output logic pll_reset_q,
    output logic boot_go_q,
    // Security register, loaded from OTP
    input wire logic [31:0] sec_reg,
    // Debug access towards tile, switch and OTP
    output logic dbg_req_q,
    output jtrc_pkg::jtrc_dbg_req_type dbg_cmd_q,
    input wire logic dbg_ack,
    input wire logic [31:0] dbg_rdata,
    // Test port
    input wire logic tck,
    input wire logic trst_n,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo_q,
    output logic tdo_oe_q,
    // Boundary scan cells
    input wire logic [NPIN-1:0] pin_in,
    output logic bs_drive_q,
    output logic [NPIN-1:0] bs_out_q
);
    localparam int BSW = (NPIN > 32) ? NPIN : 32;

    // Refuse pin counts the capture register cannot serve
    if (NPIN < 1 || NPIN > 256) begin : g_npin_bad
        $error("NPIN out of range");
    end

    typedef struct packed {
        jtrc_pkg::jtrc_tap_type st;
        logic [`JTRC_IR_W-1:0] bs_ir, ch_ir, bs_irsh, ch_irsh;
        logic [BSW-1:0] bs_dr;
        logic [`JTRC_DBG_W-1:0] ch_dr;
        logic [NPIN-1:0] bs_upd;
        logic bs_drive, blocked, req_tgl;
        jtrc_pkg::jtrc_dbg_req_type cmd;
        logic [1:0] ack_s1, ack_s2;
        logic [31:0] sec_s1, sec_s2;
        logic [NPIN-1:0] pin_s1, pin_s2;
    } jtrc_tck_type;

    typedef struct packed {
        jtrc_pkg::jtrc_boot_type st;
        logic lock_s1, lock_s2;
        logic req_s1, req_s2, req_s3;
        logic ack_tgl, req, boot_go, pll_reset;
        jtrc_pkg::jtrc_dbg_req_type cmd;
        logic [31:0] rdata;
    } jtrc_clk_type;

    jtrc_tck_type t_q, t_d;
    jtrc_clk_type c_q, c_d;
    logic [31:0] device_identification_word, usercode;
    logic jtag_off, otp_off, tdo_d, oe_d;

    // TAP state transitions, same walk for both controllers
    function automatic jtrc_pkg::jtrc_tap_type tap_next(
        jtrc_pkg::jtrc_tap_type s, logic m);
        case (s)
            jtrc_pkg::TLR: tap_next = m ? jtrc_pkg::TLR : jtrc_pkg::RTI;
            jtrc_pkg::RTI: tap_next = m ? jtrc_pkg::SEL_DR : jtrc_pkg::RTI;
            jtrc_pkg::SEL_DR: tap_next = m ? jtrc_pkg::SEL_IR : jtrc_pkg::CAP_DR;
            jtrc_pkg::CAP_DR: tap_next = m ? jtrc_pkg::EX1_DR : jtrc_pkg::SH_DR;
            jtrc_pkg::SH_DR: tap_next = m ? jtrc_pkg::EX1_DR : jtrc_pkg::SH_DR;
            jtrc_pkg::EX1_DR: tap_next = m ? jtrc_pkg::UP_DR : jtrc_pkg::PA_DR;
            jtrc_pkg::PA_DR: tap_next = m ? jtrc_pkg::EX2_DR : jtrc_pkg::PA_DR;
            jtrc_pkg::EX2_DR: tap_next = m ? jtrc_pkg::UP_DR : jtrc_pkg::SH_DR;
            jtrc_pkg::UP_DR: tap_next = m ? jtrc_pkg::SEL_DR : jtrc_pkg::RTI;
            jtrc_pkg::SEL_IR: tap_next = m ? jtrc_pkg::TLR : jtrc_pkg::CAP_IR;
            jtrc_pkg::CAP_IR: tap_next = m ? jtrc_pkg::EX1_IR : jtrc_pkg::SH_IR;
            jtrc_pkg::SH_IR: tap_next = m ? jtrc_pkg::EX1_IR : jtrc_pkg::SH_IR;
            jtrc_pkg::EX1_IR: tap_next = m ? jtrc_pkg::UP_IR : jtrc_pkg::PA_IR;
            jtrc_pkg::PA_IR: tap_next = m ? jtrc_pkg::EX2_IR : jtrc_pkg::PA_IR;
            jtrc_pkg::EX2_IR: tap_next = m ? jtrc_pkg::UP_IR : jtrc_pkg::SH_IR;
            jtrc_pkg::UP_IR: tap_next = m ? jtrc_pkg::SEL_DR : jtrc_pkg::RTI;
            default: tap_next = jtrc_pkg::TLR;
        endcase
    endfunction : tap_next

    // Identification words
    assign device_identification_word = {ID_VERSION, ID_PART, ID_MAKER, `JTRC_DEVICE_IDENTIFICATION_WORD_LSB};
    assign usercode = {t_q.sec_s2[`JTRC_USERID_MSB:`JTRC_USERID_LSB],
                       UC_FIXED};
    assign jtag_off = t_q.sec_s2[`JTRC_SEC_JTAG_OFF];
    assign otp_off = t_q.sec_s2[`JTRC_SEC_JTAG_OTP_OFF];

    // TCK side: both TAPs, boundary TAP nearest TDI
    always_comb begin
        int blen;
        int clen;
        blen = 1;
        clen = 1;
        t_d = t_q;
        t_d.st = tap_next(t_q.st, tms);
        t_d.sec_s1 = sec_reg;
        t_d.sec_s2 = t_q.sec_s1;
        t_d.pin_s1 = pin_in;
        t_d.pin_s2 = t_q.pin_s1;
        t_d.ack_s1 = {1'b0, c_q.ack_tgl};
        t_d.ack_s2 = t_q.ack_s1;
        case (t_q.bs_ir)
            jtrc_pkg::BS_DEVICE_IDENTIFICATION_WORD, jtrc_pkg::BS_USERCODE: blen = 32;
            jtrc_pkg::BS_EXTEST, jtrc_pkg::BS_SAMPLE: blen = NPIN;
            default: blen = 1;
        endcase
        clen = (t_q.ch_ir == jtrc_pkg::CH_DEBUG) ? `JTRC_DBG_W : 1;
        case (t_q.st)
            jtrc_pkg::TLR: begin
                t_d.bs_ir = jtrc_pkg::BS_DEVICE_IDENTIFICATION_WORD;
                t_d.ch_ir = jtrc_pkg::CH_BYPASS;
                t_d.bs_drive = 1'b0;
            end
            jtrc_pkg::CAP_IR: begin
                t_d.bs_irsh = `JTRC_IR_CAPTURE;
                t_d.ch_irsh = `JTRC_IR_CAPTURE;
            end
            jtrc_pkg::SH_IR: begin
                t_d.bs_irsh = {tdi, t_q.bs_irsh[`JTRC_IR_W-1:1]};
                t_d.ch_irsh = {t_q.bs_irsh[0], t_q.ch_irsh[`JTRC_IR_W-1:1]};
            end
            jtrc_pkg::UP_IR: begin
                // Disabled port degrades both TAPs to bypass
                t_d.bs_ir = jtag_off ? jtrc_pkg::BS_BYPASS : t_q.bs_irsh;
                t_d.ch_ir = jtag_off ? jtrc_pkg::CH_BYPASS : t_q.ch_irsh;
                t_d.bs_drive = !jtag_off && (t_q.bs_irsh == jtrc_pkg::BS_EXTEST);
            end
            jtrc_pkg::CAP_DR: begin
                t_d.bs_dr = '0;
                case (t_q.bs_ir)
                    jtrc_pkg::BS_DEVICE_IDENTIFICATION_WORD: t_d.bs_dr[31:0] = device_identification_word;
                    jtrc_pkg::BS_USERCODE: t_d.bs_dr[31:0] = usercode;
                    jtrc_pkg::BS_EXTEST, jtrc_pkg::BS_SAMPLE:
                        t_d.bs_dr[NPIN-1:0] = t_q.pin_s2;
                    default: t_d.bs_dr = '0;
                endcase
                t_d.ch_dr = '0;
                if (t_q.ch_ir == jtrc_pkg::CH_DEBUG) begin
                    t_d.ch_dr[`JTRC_DBG_DONE] = (t_q.ack_s2[0] == t_q.req_tgl);
                    t_d.ch_dr[`JTRC_DBG_BLOCKED] = t_q.blocked;
                    t_d.ch_dr[31:0] = c_q.rdata; // Stable once done reads set
                end
            end
            jtrc_pkg::SH_DR: begin
                t_d.bs_dr = t_q.bs_dr >> 1;
                t_d.bs_dr[blen-1] = tdi;
                t_d.ch_dr = t_q.ch_dr >> 1;
                t_d.ch_dr[clen-1] = t_q.bs_dr[0];
            end
            jtrc_pkg::UP_DR: begin
                if (t_q.bs_ir == jtrc_pkg::BS_EXTEST) begin
                    t_d.bs_upd = t_q.bs_dr[NPIN-1:0];
                end
                if (t_q.ch_ir == jtrc_pkg::CH_DEBUG && !jtag_off) begin
                    // OTP lock refuses the request, visible as blocked
                    if (t_q.ch_dr[`JTRC_DBG_TGT_MSB:`JTRC_DBG_TGT_LSB]
                        == jtrc_pkg::TGT_OTP && otp_off) begin
                        t_d.blocked = 1'b1;
                    end else begin
                        t_d.blocked = 1'b0;
                        t_d.cmd = t_q.ch_dr;
                        t_d.req_tgl = !t_q.req_tgl;
                    end
                end
            end
            default: t_d.st = t_d.st;
        endcase
    end

    // TCK registers, test reset acts without the clock
    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            t_q <= '0;
            t_q.bs_ir <= jtrc_pkg::BS_DEVICE_IDENTIFICATION_WORD;
            t_q.ch_ir <= jtrc_pkg::CH_BYPASS;
        end else begin
            t_q <= t_d;
        end
    end

    // TDO changes on the falling edge, per the usual TAP timing
    assign oe_d = (t_q.st == jtrc_pkg::SH_DR) || (t_q.st == jtrc_pkg::SH_IR);
    assign tdo_d = (t_q.st == jtrc_pkg::SH_IR) ? t_q.ch_irsh[0] : t_q.ch_dr[0];
    always_ff @(negedge tck or negedge trst_n) begin
        if (!trst_n) begin
            tdo_q <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else begin
            tdo_q <= tdo_d;
            tdo_oe_q <= oe_d;
        end
    end
    assign bs_drive_q = t_q.bs_drive;
    assign bs_out_q = t_q.bs_upd;

    // System side: boot sequencing and debug request landing
    always_comb begin
        c_d = c_q;
        c_d.lock_s1 = pll_lock;
        c_d.lock_s2 = c_q.lock_s1;
        c_d.req_s1 = t_q.req_tgl;
        c_d.req_s2 = c_q.req_s1;
        c_d.req_s3 = c_q.req_s2;
        c_d.req = c_q.req_s2 ^ c_q.req_s3;
        if (c_q.req_s2 ^ c_q.req_s3) begin
            c_d.cmd = t_q.cmd; // Held stable since the toggle
        end
        if (dbg_ack) begin
            c_d.rdata = dbg_rdata;
            c_d.ack_tgl = c_q.req_s3;
        end
        c_d.pll_reset = 1'b0;
        case (c_q.st)
            jtrc_pkg::B_RST: c_d.st = jtrc_pkg::B_WAIT;
            jtrc_pkg::B_WAIT: begin
                if (c_q.lock_s2) begin
                    c_d.st = jtrc_pkg::B_BOOT;
                    c_d.boot_go = 1'b1;
                end
            end
            jtrc_pkg::B_BOOT: c_d.boot_go = 1'b1;
            default: c_d.st = jtrc_pkg::B_RST;
        endcase
    end

    // Global reset asserts at once, no clock needed
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            c_q <= '0;
            c_q.pll_reset <= 1'b1;
        end else if (srst) begin
            c_q <= '0;
            c_q.pll_reset <= 1'b1;
        end else begin
            c_q <= c_d;
        end
    end
    assign pll_reset_q = c_q.pll_reset;
    assign boot_go_q = c_q.boot_go;
    assign dbg_req_q = c_q.req;
    assign dbg_cmd_q = c_q.cmd;

    chk_reset_ir: assert property (@(posedge tck) disable iff (!trst_n)
        t_q.st == jtrc_pkg::TLR |=> t_q.bs_ir == jtrc_pkg::BS_DEVICE_IDENTIFICATION_WORD
        && t_q.ch_ir == jtrc_pkg::CH_BYPASS)
        else $error("TAPs not reset to default instructions");
    chk_chain_two: assert property (@(posedge tck) disable iff (!trst_n)
        ((t_q.st == jtrc_pkg::SH_DR && t_q.bs_ir == jtrc_pkg::BS_BYPASS
        && t_q.ch_ir == jtrc_pkg::CH_BYPASS)[*2]) |=>
        t_q.ch_dr[0] == $past(tdi, 2))
        else $error("Bypass chain is not two bits long");
    chk_ir_capture: assert property (@(posedge tck) disable iff (!trst_n)
        t_q.st == jtrc_pkg::CAP_IR |=> t_q.bs_irsh[1:0] == 2'b01)
        else $error("IR capture pattern wrong");
    chk_id_word: assert property (@(posedge tck) disable iff (!trst_n)
        t_q.st == jtrc_pkg::CAP_DR && t_q.bs_ir == jtrc_pkg::BS_DEVICE_IDENTIFICATION_WORD
        |=> t_q.bs_dr[31:0] == device_identification_word && t_q.bs_dr[0])
        else $error("DEVICE_IDENTIFICATION_WORD capture wrong");
    chk_user_id: assert property (@(posedge tck) disable iff (!trst_n)
        t_q.st == jtrc_pkg::CAP_DR && t_q.bs_ir == jtrc_pkg::BS_USERCODE
        |=> t_q.bs_dr[31:22] == $past(t_q.sec_s2[31:22]))
        else $error("User ID not from security bits");
    chk_jtag_off: assert property (@(posedge tck) disable iff (!trst_n)
        jtag_off && t_q.st == jtrc_pkg::UP_IR |=>
        t_q.bs_ir == jtrc_pkg::BS_BYPASS && t_q.ch_ir == jtrc_pkg::CH_BYPASS)
        else $error("Disabled port accepted an instruction");
    chk_otp_block: assert property (@(posedge tck) disable iff (!trst_n)
        t_q.st == jtrc_pkg::UP_DR && t_q.ch_ir == jtrc_pkg::CH_DEBUG
        && otp_off && t_q.ch_dr[33:32] == jtrc_pkg::TGT_OTP
        |=> t_q.req_tgl == $past(t_q.req_tgl) && t_q.blocked)
        else $error("OTP access passed while locked");
    chk_boot_lock: assert property (@(posedge clk) disable iff (srst)
        $rose(c_q.boot_go) |-> $past(pll_lock, 3)
        && $past(c_q.st) == jtrc_pkg::B_WAIT)
        else $error("Boot started without PLL lock");
    chk_req_pulse: assert property (@(posedge clk) disable iff (srst)
        c_q.req |=> !c_q.req)
        else $error("Debug request longer than one cycle");
endmodule : jtrc_top

/* jtrc_host.sv */
// JTAG host model that drives the test port in whole frames
`timescale 1ns/1ps
module jtrc_host (
    // Test port towards the device
    output logic tck,
    output logic tms,
    output logic tdi,
    output logic trst_n,
    input wire logic tdo_q
);
    // Clock parked low; reset edge after time zero so it is seen
    initial begin
        tck = 1'h0;
        tms = 1'h1;
        tdi = 1'h0;
        #1;
        trst_n = 1'h0;
    end

    // One test clock: inputs move while low, TDO taken at the rise
    task automatic tick(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #3;
        o = tdo_q;
        tck = 1'h1;
        #3;
        tck = 1'h0;
    endtask : tick

    // Reset pulse longer than 100 ns, clock stopped, then go idle
    task automatic test_reset();
        logic o;
        trst_n = 1'h0;
        #120;
        trst_n = 1'h1;
        tick(1'h0, 1'h0, o);
    endtask : test_reset

    // IR or DR scan from idle to idle, LSB first; idle ticks first
    // so that the device's synchronisers see a few clocks
    task automatic scan(input logic ir, input int n,
            input logic [63:0] din, output logic [63:0] dout);
        logic o;
        dout = '0;
        repeat (3) tick(1'h0, 1'h0, o);
        tick(1'h1, 1'h0, o);
        if (ir) tick(1'h1, 1'h0, o);
        tick(1'h0, 1'h0, o);
        tick(1'h0, 1'h0, o);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], o);
            dout[i] = o;
        end
        tick(1'h1, 1'h0, o);
        tick(1'h0, 1'h0, o);
    endtask : scan
endmodule : jtrc_host

/* tb_top.sv */
// Self-checking bench for the two-TAP chain and reset sequencing
`timescale 1ns/1ps
`include "jtrc_params.svh"
module tb_top;
    logic clk, srst, rst_n, pll_lock, dbg_ack;
    logic [31:0] sec_reg, dbg_rdata;
    logic [15:0] pin_in, bs_out_q;
    logic tck, tms, tdi, trst_n, tdo_q, tdo_oe_q;
    logic pll_reset_q, boot_go_q, dbg_req_q, bs_drive_q;
    jtrc_pkg::jtrc_dbg_req_type dbg_cmd_q;
    int fail_count, n_compared, req_cnt, oe_cnt;
    logic [63:0] dout;
    localparam logic [31:0] ID_EXP = {`JTRC_ID_VERSION, `JTRC_ID_PART,
        `JTRC_ID_MAKER, `JTRC_DEVICE_IDENTIFICATION_WORD_LSB};

    jtrc_top dut (.clk(clk), .srst(srst), .rst_n(rst_n),
        .pll_lock(pll_lock), .pll_reset_q(pll_reset_q),
        .boot_go_q(boot_go_q), .sec_reg(sec_reg), .dbg_req_q(dbg_req_q),
        .dbg_cmd_q(dbg_cmd_q), .dbg_ack(dbg_ack), .dbg_rdata(dbg_rdata),
        .tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi), .tdo_q(tdo_q),
        .tdo_oe_q(tdo_oe_q), .pin_in(pin_in), .bs_drive_q(bs_drive_q),
        .bs_out_q(bs_out_q));
    jtrc_host host (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
        .tdo_q(tdo_q));

    // System clock, 10 ns
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    // Debug target: acks one cycle after each request, data inverted
    always @(posedge clk) begin
        dbg_ack <= dbg_req_q;
        dbg_rdata <= ~dbg_cmd_q.data;
        if (dbg_req_q === 1'h1) req_cnt <= req_cnt + 1;
    end

    // Count test clocks with TDO driven, one per shifted bit
    always @(posedge tck) begin
        if (tdo_oe_q === 1'h1) oe_cnt <= oe_cnt + 1;
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic end_of_test();
        $display("compared=%0d mismatches=%0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test

    // Async assert, then boot held off until lock is seen
    task automatic t_boot();
        @(posedge clk);
        rst_n <= 1'h0;
        #2;
        chk(pll_reset_q, 1);
        chk(boot_go_q, 0);
        repeat (12) @(posedge clk);
        rst_n <= 1'h1;
        repeat (6) @(posedge clk);
        #1;
        chk({pll_reset_q, boot_go_q}, 0);
        pll_lock <= 1'h1;
        @(posedge clk);
        #1;
        chk(boot_go_q, 0);
        repeat (5) @(posedge clk);
        #1;
        chk(boot_go_q, 1);
    endtask : t_boot

    // Default instruction after reset is the identification word
    task automatic t_device_identification_word();
        int oe0;
        oe0 = oe_cnt;
        host.scan(1'h0, 33, '0, dout);
        chk(dout, {31'h0, ID_EXP, 1'h0});
        chk(oe_cnt - oe0, 33);
        chk(bs_drive_q, 0);
    endtask : t_device_identification_word

    // IR capture pattern, EXTEST drive, async test reset clears it
    task automatic t_extest();
        host.scan(1'h1, 8, {jtrc_pkg::BS_EXTEST, jtrc_pkg::CH_BYPASS}, dout);
        chk(dout, 64'h11);
        chk(bs_drive_q, 1);
        host.scan(1'h0, 17, {47'h0, 16'hc3a5, 1'h0}, dout);
        chk(dout[16:0], {16'h3c5a, 1'h0});
        chk(bs_out_q, 16'hc3a5);
        host.test_reset();
        chk(bs_drive_q, 0);
        chk(bs_out_q, 0);
        t_device_identification_word();
    endtask : t_extest

    // SAMPLE captures pins without driving or updating them
    task automatic t_sample();
        host.scan(1'h1, 8, {jtrc_pkg::BS_SAMPLE, jtrc_pkg::CH_BYPASS}, dout);
        chk(dout, 64'h11);
        host.scan(1'h0, 17, {47'h0, 16'hffff, 1'h0}, dout);
        chk(dout[16:0], {16'h3c5a, 1'h0});
        chk({bs_drive_q, bs_out_q}, 0);
    endtask : t_sample

    // User code word carries security bits 31..22
    task automatic t_usercode(input logic [31:0] sec);
        @(posedge clk);
        sec_reg <= sec;
        host.scan(1'h1, 8, {jtrc_pkg::BS_USERCODE, jtrc_pkg::CH_BYPASS},
            dout);
        host.scan(1'h0, 33, '0, dout);
        chk(dout, {31'h0, sec[31:22], `JTRC_UC_FIXED, 1'h0});
    endtask : t_usercode

    // Write one debug command, check it, then read back the answer
    task automatic dbg_op(input logic [1:0] t, input logic [31:0] d,
            input logic blk);
        int cnt0;
        cnt0 = req_cnt;
        host.scan(1'h0, 36, {29'h0, 1'h1, t, d}, dout);
        for (int i = 0; i < 40 && req_cnt == cnt0; i++) @(posedge clk);
        if (blk) begin
            chk(req_cnt - cnt0, 0);
        end else begin
            chk(req_cnt - cnt0, 1);
            chk(dbg_cmd_q, {1'h1, t, d});
        end
        repeat (8) @(posedge clk);
        host.scan(1'h0, 36, '0, dout);
        if (blk) begin
            chk(dout[33], 1);
        end else begin
            chk(dout[34:0], {3'h4, ~d});
        end
        // Read-back update issues its own request; let it land
        repeat (10) @(posedge clk);
    endtask : dbg_op

    // Every target in turn, then OTP with JTAG access to it blocked
    task automatic t_debug();
        @(posedge clk);
        sec_reg <= '0;
        host.scan(1'h1, 8, {jtrc_pkg::BS_BYPASS, jtrc_pkg::CH_DEBUG}, dout);
        for (int k = 0; k < 3; k++) dbg_op(2'(k), 32'h5a3c_0f10 + k, 1'h0);
        @(posedge clk);
        sec_reg <= 32'h0000_2000;
        dbg_op(jtrc_pkg::TGT_OTP, 32'h0bad_f00d, 1'h1);
    endtask : t_debug

    // JTAG disabled: DEVICE_IDENTIFICATION_WORD request yields bypass, no debug traffic
    task automatic t_jtag_off();
        int cnt0;
        @(posedge clk);
        sec_reg <= 32'h0000_0001;
        cnt0 = req_cnt;
        host.scan(1'h1, 8, {jtrc_pkg::BS_DEVICE_IDENTIFICATION_WORD, jtrc_pkg::CH_DEBUG}, dout);
        host.scan(1'h0, 36, 64'h7_ffff_ffff, dout);
        chk(dout[1:0], 0);
        repeat (20) @(posedge clk);
        chk(req_cnt - cnt0, 0);
    endtask : t_jtag_off

    // Main sequence: both resets held, then the scenarios
    initial begin
        fail_count = 0;
        n_compared = 0;
        req_cnt = 0;
        oe_cnt = 0;
        srst = 1'h1;
        rst_n = 1'h0;
        pll_lock = 1'h0;
        sec_reg = '0;
        dbg_ack = 1'h0;
        dbg_rdata = '0;
        pin_in = 16'h3c5a;
        repeat (15) @(posedge clk);
        rst_n <= 1'h1;
        repeat (5) @(posedge clk);
        srst <= 1'h0;
        t_boot();
        host.test_reset();
        t_device_identification_word();
        t_extest();
        t_sample();
        t_usercode(32'h0000_0000);
        t_usercode(32'ha5ff_8000);
        t_debug();
        t_jtag_off();
        end_of_test();
    end

    // Watchdog, well beyond the expected run of a few microseconds
    initial begin
        #100000;
        fail_count++;
        end_of_test();
    end
endmodule : tb_top
